// ==== sfrpc_core.sv ====
/*
 * sfrpc_core: special-function register space, dual data pointers, stack
 * pointer, port latches, timers and machine-cycle accounting.
 * Assumes the sequencer on the same clock issues one request per cycle and
 * reports instruction boundaries; no reset synchroniser is needed.
 */
`timescale 1ns/1ps
module sfrpc_core
	import sfrpc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input sfrpc_req_s req,
	input wire logic xmove, // external data move uses the active pointer
	input wire logic [7:0] xmove_wdata,
	input wire logic xmove_wr,
	input wire logic instr_start, // first byte of a new instruction
	input wire logic instr_byte, // one opcode/operand byte fetched
	input wire logic flags_wr, // ALU flag update this cycle
	input wire logic [7:0] flags_val,
	input wire logic [7:0] ext_port_in_0,
	output sfrpc_rsp_s rsp,
	output logic [15:0] xmove_addr,
	output logic [7:0] xmove_rdata,
	output logic [7:0] port_out_0,
	output logic [7:0] port_out_1,
	output logic [7:0] port_out_2,
	output logic [7:0] port_out_3,
	output logic [7:0] stack_ptr,
	output logic [7:0] arith_out,
	output logic [7:0] status_out,
	output logic [7:0] instr_cycles
);
	logic [7:0] port_reg [4], port_next [4];
	logic [7:0] sp_reg, sp_next, psel_reg, psel_next, tctl_reg, tctl_next, clkc_reg, clkc_next;
	logic [7:0] acc_reg, acc_next, psw_reg, psw_next;
	logic [15:0] dp0_reg, dp0_next, dp1_reg, dp1_next;
	logic [7:0] xram [1024];
	logic [15:0] xaddr_reg;
	logic [7:0] xrd_reg;
	sfrpc_rsp_s rsp_reg, rsp_next;
	logic [7:0] cyc_reg, cyc_next, last_cyc_reg, last_cyc_next;
	logic [7:0] in_s1, in_s2;
	logic [15:0] tcount [NUM_TMR];
	logic [NUM_TMR-1:0] wr_lo, wr_hi;
	logic acc_en, wr_en, bit_en;
	logic [7:0] cur, newv, wval;
	logic [15:0] act_dp;

	// decode used for both access gating and read data
	function automatic logic bit_addressable(input logic [7:0] a);
		return a[2:0] == 3'h0;
	endfunction

	function automatic logic [7:0] port_idx_addr(input int i);
		return (i == 0) ? A_P0 : (i == 1) ? A_P1 : (i == 2) ? A_P2 : A_P3;
	endfunction

	// two-flop sync on the external pin before any read
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			in_s1 <= RST_ZERO;
			in_s2 <= RST_ZERO;
		end else begin
			in_s1 <= ext_port_in_0;
			in_s2 <= in_s1;
		end
	end

	// only direct accesses in the upper half reach registers
	assign acc_en = req.valid && req.direct && (req.addr >= SFR_BASE);
	assign bit_en = acc_en && (req.op == SFRPC_OP_BITSET || req.op == SFRPC_OP_BITCLR)
		&& bit_addressable(req.addr);
	assign wr_en = (acc_en && req.op == SFRPC_OP_WRITE) || bit_en;
	assign act_dp = psel_reg[PSEL_SEL_BIT] ? dp1_reg : dp0_reg;

	// current value at the decoded address
	always_comb begin
		cur = RST_ZERO;
		if (req.addr == A_P0) begin
			cur = in_s2 & port_reg[0]; // pin read through latch, open-drain style
		end else if (req.addr == A_P1) begin
			cur = port_reg[1];
		end else if (req.addr == A_P2) begin
			cur = port_reg[2];
		end else if (req.addr == A_P3) begin
			cur = port_reg[3];
		end else if (req.addr == A_SP) begin
			cur = sp_reg;
		end else if (req.addr == A_DPL) begin
			cur = dp0_reg[7:0];
		end else if (req.addr == A_DPH) begin
			cur = dp0_reg[15:8];
		end else if (req.addr == A_DPL1) begin
			cur = dp1_reg[7:0];
		end else if (req.addr == A_DPH1) begin
			cur = dp1_reg[15:8];
		end else if (req.addr == A_PSEL) begin
			cur = psel_reg;
		end else if (req.addr == A_TCTL) begin
			cur = tctl_reg;
		end else if (req.addr == A_CLKC) begin
			cur = clkc_reg;
		end else if (req.addr == A_TL0) begin
			cur = tcount[0][7:0];
		end else if (req.addr == A_TH0) begin
			cur = tcount[0][15:8];
		end else if (req.addr == A_TL1) begin
			cur = tcount[1][7:0];
		end else if (req.addr == A_TH1) begin
			cur = tcount[1][15:8];
		end else if (req.addr == A_TL2) begin
			cur = tcount[2][7:0];
		end else if (req.addr == A_TH2) begin
			cur = tcount[2][15:8];
		end else if (req.addr == A_STATUSW) begin
			cur = psw_reg;
		end else if (req.addr == A_ARITH) begin
			cur = acc_reg;
		end
	end

	// read-modify-write value for bit writes; byte writes take wdata as is
	always_comb begin
		newv = cur;
		if (req.addr == A_P0) begin
			newv = port_reg[0]; // bit ops on a port modify the latch
		end
		if (req.op == SFRPC_OP_BITSET) begin
			newv[req.bit_idx] = 1'b1;
		end else if (req.op == SFRPC_OP_BITCLR) begin
			newv[req.bit_idx] = 1'b0;
		end
		wval = (req.op == SFRPC_OP_WRITE) ? req.wdata : newv;
	end

	// register next-state; software write lands at the end of this cycle
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			port_next[i] = port_reg[i];
			if (wr_en && req.addr == port_idx_addr(i)) begin
				port_next[i] = wval;
			end
		end
		sp_next = (wr_en && req.addr == A_SP) ? wval : sp_reg;
		tctl_next = (wr_en && req.addr == A_TCTL) ? wval : tctl_reg;
		clkc_next = (wr_en && req.addr == A_CLKC) ? wval : clkc_reg;
		acc_next = (wr_en && req.addr == A_ARITH) ? wval : acc_reg;
		// flag hardware update only when software is not writing it
		psw_next = psw_reg;
		if (flags_wr) begin
			psw_next = flags_val;
		end
		if (wr_en && req.addr == A_STATUSW) begin
			psw_next = wval;
		end
		psel_next = (wr_en && req.addr == A_PSEL) ? wval : psel_reg;
		dp0_next = dp0_reg;
		dp1_next = dp1_reg;
		if (wr_en && req.addr == A_DPL) dp0_next[7:0] = wval;
		if (wr_en && req.addr == A_DPH) dp0_next[15:8] = wval;
		if (wr_en && req.addr == A_DPL1) dp1_next[7:0] = wval;
		if (wr_en && req.addr == A_DPH1) dp1_next[15:8] = wval;
		// after an external move: optional step, then optional toggle
		if (xmove) begin
			if (psel_reg[PSEL_AUTO_BIT]) begin
				if (psel_reg[PSEL_SEL_BIT]) begin
					dp1_next = psel_reg[PSEL_DEC_BIT] ? dp1_reg - 16'h0001 : dp1_reg + 16'h0001;
				end else begin
					dp0_next = psel_reg[PSEL_DEC_BIT] ? dp0_reg - 16'h0001 : dp0_reg + 16'h0001;
				end
			end
			if (psel_reg[PSEL_TOGGLE_BIT]) begin
				psel_next[PSEL_SEL_BIT] = ~psel_reg[PSEL_SEL_BIT];
			end
		end
		rsp_next.valid = req.valid;
		rsp_next.hit = acc_en;
		rsp_next.rdata = acc_en ? cur : RST_ZERO;
		rsp_next.bit_val = acc_en && bit_addressable(req.addr) && cur[req.bit_idx];
	end

	// one machine cycle per clock: count clocks from one instruction start to the next
	always_comb begin
		cyc_next = cyc_reg + 8'h01;
		last_cyc_next = last_cyc_reg;
		if (instr_start) begin
			last_cyc_next = cyc_reg;
			cyc_next = 8'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int i = 0; i < 4; i++) begin
				port_reg[i] <= RST_PORT;
			end
			sp_reg <= RST_SP;
			psel_reg <= RST_PSEL;
			tctl_reg <= RST_ZERO;
			clkc_reg <= RST_ZERO;
			acc_reg <= RST_ZERO;
			psw_reg <= RST_ZERO;
			dp0_reg <= 16'h0000;
			dp1_reg <= 16'h0000;
			rsp_reg <= '0;
			cyc_reg <= 8'h00;
			last_cyc_reg <= 8'h00;
			xaddr_reg <= 16'h0000;
			xrd_reg <= RST_ZERO;
		end else begin
			port_reg <= port_next;
			sp_reg <= sp_next;
			psel_reg <= psel_next;
			tctl_reg <= tctl_next;
			clkc_reg <= clkc_next;
			acc_reg <= acc_next;
			psw_reg <= psw_next;
			dp0_reg <= dp0_next;
			dp1_reg <= dp1_next;
			rsp_reg <= rsp_next;
			cyc_reg <= cyc_next;
			last_cyc_reg <= last_cyc_next;
			xaddr_reg <= act_dp;
			xrd_reg <= xram[act_dp[9:0]];
		end
	end

	// on-chip external-data memory, no reset on storage
	always_ff @(posedge sys_clk) begin
		if (xmove && xmove_wr && act_dp[15:10] == 6'h00) begin
			xram[act_dp[9:0]] <= xmove_wdata;
		end
	end

	// timers: two locations each, rate bits in the clock control register
	generate
		for (genvar t = 0; t < NUM_TMR; t++) begin : g_tmr
			localparam logic [7:0] LO = (t == 0) ? A_TL0 : (t == 1) ? A_TL1 : A_TL2;
			localparam logic [7:0] HI = (t == 0) ? A_TH0 : (t == 1) ? A_TH1 : A_TH2;
			assign wr_lo[t] = wr_en && req.addr == LO;
			assign wr_hi[t] = wr_en && req.addr == HI;
			sfrpc_timer u_tmr (
				.sys_clk(sys_clk),
				.rst(rst),
				.run((t == 0) ? tctl_reg[TCTL_RUN0_BIT] : (t == 1) ? tctl_reg[TCTL_RUN1_BIT] : tctl_reg[TCTL_RUN2_BIT]),
				.fast(clkc_reg[CLKC_FAST0_BIT + t]),
				.wr_lo(wr_lo[t]),
				.wr_hi(wr_hi[t]),
				.wdata(wval),
				.count(tcount[t])
			);
		end
	endgenerate

	assign rsp = rsp_reg;
	assign xmove_addr = xaddr_reg;
	assign xmove_rdata = xrd_reg;
	assign port_out_0 = port_reg[0];
	assign port_out_1 = port_reg[1];
	assign port_out_2 = port_reg[2];
	assign port_out_3 = port_reg[3];
	assign stack_ptr = sp_reg;
	assign arith_out = acc_reg;
	assign status_out = psw_reg;
	assign instr_cycles = last_cyc_reg;

	property p_indirect_blocked;
		@(posedge sys_clk) disable iff (rst)
		(req.valid && !req.direct) |=> (!rsp.hit && rsp.rdata == RST_ZERO);
	endproperty
	a_indirect_blocked: assert property (p_indirect_blocked) else $error("indirect access reached register space");

	property p_bit_only_aligned;
		@(posedge sys_clk) disable iff (rst)
		(acc_en && (req.op == SFRPC_OP_BITSET || req.op == SFRPC_OP_BITCLR) && !bit_addressable(req.addr) && !xmove)
		|=> ($stable(psel_reg) && $stable(stack_ptr) && $stable(dp0_reg) && $stable(dp1_reg));
	endproperty
	a_bit_only_aligned: assert property (p_bit_only_aligned) else $error("bit op on unaligned address");

	property p_toggle;
		@(posedge sys_clk) disable iff (rst)
		(xmove && psel_reg[PSEL_TOGGLE_BIT] && !(wr_en && req.addr == A_PSEL))
		|=> (psel_reg[PSEL_SEL_BIT] != $past(psel_reg[PSEL_SEL_BIT]));
	endproperty
	a_toggle: assert property (p_toggle) else $error("pointer select did not toggle");

	property p_addr_from_active;
		@(posedge sys_clk) disable iff (rst)
		1'b1 |=> (xmove_addr == $past(psel_reg[PSEL_SEL_BIT] ? dp1_reg : dp0_reg));
	endproperty
	a_addr_from_active: assert property (p_addr_from_active) else $error("wrong pointer drives address");

	property p_autoinc;
		@(posedge sys_clk) disable iff (rst)
		(xmove && psel_reg[PSEL_AUTO_BIT] && !psel_reg[PSEL_DEC_BIT] && !psel_reg[PSEL_SEL_BIT] && !wr_en)
		|=> (dp0_reg == $past(dp0_reg) + 16'h0001);
	endproperty
	a_autoinc: assert property (p_autoinc) else $error("pointer auto increment missed");

	property p_port_hold;
		@(posedge sys_clk) disable iff (rst)
		(!wr_en) |=> $stable(port_out_1);
	endproperty
	a_port_hold: assert property (p_port_hold) else $error("port latch changed without write");

	property p_write_visible;
		@(posedge sys_clk) disable iff (rst)
		(req.valid && req.direct && req.op == SFRPC_OP_WRITE && req.addr == A_SP) |=> (stack_ptr == $past(req.wdata));
	endproperty
	a_write_visible: assert property (p_write_visible) else $error("write not visible next cycle");

	property p_cycle_count;
		@(posedge sys_clk) disable iff (rst)
		instr_start ##1 !instr_start ##1 instr_start |=> (instr_cycles == XMOVE_CYCLES);
	endproperty
	a_cycle_count: assert property (p_cycle_count) else $error("two-cycle instruction miscounted");

	c_toggle: cover property (@(posedge sys_clk) disable iff (rst) xmove && psel_reg[PSEL_TOGGLE_BIT]);
	c_bitset: cover property (@(posedge sys_clk) disable iff (rst) bit_en);
	c_three: cover property (@(posedge sys_clk) disable iff (rst) instr_start && cyc_reg == DMOVE_CYCLES);
endmodule

// ==== sfrpc_core_tb.sv ====
/*
 * sfrpc_core_tb: self-checking bench for the register space and pointer core.
 * Assumes the sequencer model drives all request inputs; pin input is static.
 */
`timescale 1ns/1ps
module sfrpc_core_tb
	import sfrpc_pkg::*;
;
	logic sys_clk, rst, xmove, xmove_wr, instr_start, instr_byte, flags_wr;
	logic [7:0] xmove_wdata, flags_val, ext_port_in_0, xmove_rdata, arith_out, status_out, instr_cycles;
	logic [7:0] port_out_0, port_out_1, port_out_2, port_out_3, stack_ptr;
	logic [15:0] xmove_addr;
	sfrpc_req_s req;
	sfrpc_rsp_s rsp;
	int failures = 0;
	int samples_checked = 0;
	sfrpc_core u_sfrpc_core (.sys_clk(sys_clk), .rst(rst), .req(req), .xmove(xmove), .xmove_wdata(xmove_wdata),
		.xmove_wr(xmove_wr), .instr_start(instr_start), .instr_byte(instr_byte), .flags_wr(flags_wr),
		.flags_val(flags_val), .ext_port_in_0(ext_port_in_0), .rsp(rsp), .xmove_addr(xmove_addr),
		.xmove_rdata(xmove_rdata), .port_out_0(port_out_0), .port_out_1(port_out_1), .port_out_2(port_out_2),
		.port_out_3(port_out_3), .stack_ptr(stack_ptr), .arith_out(arith_out), .status_out(status_out),
		.instr_cycles(instr_cycles));
	sfrpc_seq_model u_sfrpc_seq_model (.sys_clk(sys_clk), .req(req), .xmove(xmove), .xmove_wdata(xmove_wdata),
		.xmove_wr(xmove_wr), .instr_start(instr_start), .instr_byte(instr_byte), .flags_wr(flags_wr),
		.flags_val(flags_val));
	// 100 ns clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic wrap_up();
		if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// answer lands at the taking edge, so look just after it
	task automatic rq(input sfrpc_op_e op, input logic dir, input logic [7:0] a, input logic [2:0] b,
		input logic [7:0] d);
		u_sfrpc_seq_model.acc(op, dir, a, b, d, 1'b0, 8'h00);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		rq(SFRPC_OP_WRITE, 1'b1, a, 3'h0, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		rq(SFRPC_OP_READ, 1'b1, a, 3'h0, 8'h00);
		cmp({6'h00, rsp.valid, rsp.hit, rsp.rdata}, {8'h03, exp});
	endtask
	// pointer output follows the select one cycle late
	task automatic ptr_is(input logic [15:0] exp);
		@(posedge sys_clk);
		#1;
		cmp(xmove_addr, exp);
	endtask
	task automatic t_reset();
		rd(A_SP, RST_SP);
		rd(A_PSEL, RST_PSEL);
		rd(A_DPL, RST_ZERO);
		rd(A_P0, 8'hA5);
		cmp(port_out_3, RST_PORT);
	endtask
	task automatic t_access();
		logic [7:0] ports [3] = '{A_P1, A_P2, A_P3};
		wr(A_SP, 8'h5A);
		cmp(stack_ptr, 8'h5A);
		rd(A_SP, 8'h5A);
		for (int i = 0; i < 3; i++) begin
			wr(ports[i], 8'(8'h11 * (i + 1)));
			rd(ports[i], 8'(8'h11 * (i + 1)));
		end
		cmp({port_out_1, port_out_2, port_out_3}, 24'h112233);
		wr(A_P0, 8'h0F);
		cmp(port_out_0, 8'h0F);
		rd(A_P0, 8'h05);
		wr(A_ARITH, 8'h3C);
		cmp(arith_out, 8'h3C);
	endtask
	task automatic t_refuse();
		rq(SFRPC_OP_WRITE, 1'b0, A_SP, 3'h0, 8'h00);
		cmp({rsp.hit, rsp.rdata, stack_ptr}, 17'h0005A);
		rq(SFRPC_OP_READ, 1'b1, 8'h7F, 3'h0, 8'h00);
		cmp({rsp.hit, rsp.rdata}, 9'h000);
		rq(SFRPC_OP_BITSET, 1'b1, A_SP, 3'h0, 8'h00);
		cmp({rsp.bit_val, stack_ptr}, 9'h05A);
	endtask
	task automatic t_bits();
		wr(A_P1, 8'h00);
		rq(SFRPC_OP_BITSET, 1'b1, A_P1, 3'h3, 8'h00);
		rq(SFRPC_OP_BITSET, 1'b1, A_P1, 3'h7, 8'h00);
		cmp(port_out_1, 8'h88);
		rq(SFRPC_OP_BITCLR, 1'b1, A_P1, 3'h3, 8'h00);
		cmp(port_out_1, 8'h80);
		rq(SFRPC_OP_READ, 1'b1, A_P1, 3'h7, 8'h00);
		cmp(rsp.bit_val, 1'b1);
		rq(SFRPC_OP_READ, 1'b1, A_P1, 3'h3, 8'h00);
		cmp(rsp.bit_val, 1'b0);
	endtask
	task automatic t_pointers();
		wr(A_DPL, 8'h10);
		wr(A_DPH, 8'h00);
		wr(A_DPL1, 8'h20);
		wr(A_DPH1, 8'h03);
		wr(A_PSEL, 8'h00);
		ptr_is(16'h0010);
		u_sfrpc_seq_model.xmv(1'b1, 8'hAA);
		wr(A_PSEL, 8'h01);
		ptr_is(16'h0320);
		u_sfrpc_seq_model.xmv(1'b1, 8'h55);
		wr(A_PSEL, 8'h00);
		repeat (2) @(posedge sys_clk);
		#1;
		cmp(xmove_rdata, 8'hAA);
		wr(A_PSEL, 8'h10);
		u_sfrpc_seq_model.xmv(1'b0, 8'h00);
		rd(A_DPL, 8'h11);
		wr(A_PSEL, 8'h50);
		u_sfrpc_seq_model.xmv(1'b0, 8'h00);
		rd(A_DPL, 8'h10);
		wr(A_PSEL, 8'h20);
		u_sfrpc_seq_model.xmv(1'b0, 8'h00);
		ptr_is(16'h0320);
		repeat (2) @(posedge sys_clk);
		#1;
		cmp(xmove_rdata, 8'h55);
		u_sfrpc_seq_model.xmv(1'b0, 8'h00);
		ptr_is(16'h0010);
	endtask
	// reads spaced an exact multiple of the prescale period
	task automatic t_timers();
		logic [7:0] v1, v2;
		wr(A_TL0, 8'h00);
		wr(A_TH0, 8'h5A);
		rq(SFRPC_OP_BITSET, 1'b1, A_TCTL, 3'(TCTL_RUN0_BIT), 8'h00);
		rq(SFRPC_OP_READ, 1'b1, A_TL0, 3'h0, 8'h00);
		v1 = rsp.rdata;
		repeat (118) @(posedge sys_clk);
		rq(SFRPC_OP_READ, 1'b1, A_TL0, 3'h0, 8'h00);
		v2 = rsp.rdata;
		cmp(8'(v2 - v1), 8'h0A);
		rd(A_TH0, 8'h5A);
		wr(A_CLKC, 8'h08);
		rq(SFRPC_OP_READ, 1'b1, A_TL0, 3'h0, 8'h00);
		v1 = rsp.rdata;
		repeat (18) @(posedge sys_clk);
		rq(SFRPC_OP_READ, 1'b1, A_TL0, 3'h0, 8'h00);
		v2 = rsp.rdata;
		cmp(8'(v2 - v1), 8'h14);
		// third timer on its own fast bit, reads ten clocks apart
		wr(A_CLKC, 8'h20);
		wr(A_TCTL, 8'h04);
		rq(SFRPC_OP_READ, 1'b1, A_TL2, 3'h0, 8'h00);
		v1 = rsp.rdata;
		repeat (8) @(posedge sys_clk);
		rq(SFRPC_OP_READ, 1'b1, A_TL2, 3'h0, 8'h00);
		v2 = rsp.rdata;
		cmp(8'(v2 - v1), 8'h0A);
	endtask
	task automatic t_cycles();
		repeat (3) u_sfrpc_seq_model.instr(2);
		@(posedge sys_clk);
		#1;
		cmp(instr_cycles, {5'h00, XMOVE_CYCLES});
		// length is only known once the next instruction starts
		u_sfrpc_seq_model.instr(3);
		u_sfrpc_seq_model.instr(2);
		@(posedge sys_clk);
		#1;
		cmp(instr_cycles, {5'h00, DMOVE_CYCLES});
	endtask
	task automatic t_flags();
		u_sfrpc_seq_model.acc(SFRPC_OP_READ, 1'b1, A_ARITH, 3'h0, 8'h00, 1'b1, 8'h5A);
		#1;
		cmp(status_out, 8'h5A);
		u_sfrpc_seq_model.acc(SFRPC_OP_WRITE, 1'b1, A_STATUSW, 3'h0, 8'hC3, 1'b1, 8'h5A);
		#1;
		cmp(status_out, 8'hC3);
		rd(A_STATUSW, 8'hC3);
	endtask
	// main sequence
	initial begin
		rst = 1'b1;
		ext_port_in_0 = 8'hA5;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_access();
		t_refuse();
		t_bits();
		t_pointers();
		t_timers();
		t_cycles();
		t_flags();
		wrap_up();
	end
	// watchdog well past the expected run of under a thousand cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		wrap_up();
	end
endmodule

// ==== sfrpc_pkg.sv ====
/*
 * sfrpc_pkg: constants, types and the rule overview for the special-function
 * register space and data-pointer control block.
 * Assumes a single 10 MHz system clock and a synchronous active-high reset.
 */
// Overview of operation
// - one machine cycle per clock period
// - timers tick once per twelve clocks by default
// - each timer selectable to tick every clock
// - registers at 80h-FFh, direct access only
// - addresses ending 0h/8h allow bit operations
// - select bit 0 chooses active data pointer
// - toggle enable bit 5 alternates pointer selection
// - optional auto increment or decrement of pointer
// - active pointer addresses external data moves
// - stack pointer holds last used location
// - four port latches keep last written value
// - three 16-bit timers in two locations each
// - one cycle per byte plus one execute
// - external move two cycles, direct move three
// - flags updated as legacy counterpart does
// - 256 direct bytes plus 1kB external data
package sfrpc_pkg;
	localparam int CLK_HZ = 10000000;
	localparam logic [3:0] TMR_LEGACY_DIV = 4'hC; // clocks per legacy tick
	localparam logic [3:0] TMR_DIV_LAST = 4'hB;
	localparam logic [7:0] SFR_BASE = 8'h80;
	localparam logic [7:0] A_P0 = 8'h80;
	localparam logic [7:0] A_SP = 8'h81;
	localparam logic [7:0] A_DPL = 8'h82;
	localparam logic [7:0] A_DPH = 8'h83;
	localparam logic [7:0] A_DPL1 = 8'h84;
	localparam logic [7:0] A_DPH1 = 8'h85;
	localparam logic [7:0] A_PSEL = 8'h86;
	localparam logic [7:0] A_TCTL = 8'h88;
	localparam logic [7:0] A_TL0 = 8'h8A;
	localparam logic [7:0] A_TL1 = 8'h8B;
	localparam logic [7:0] A_TH0 = 8'h8C;
	localparam logic [7:0] A_TH1 = 8'h8D;
	localparam logic [7:0] A_CLKC = 8'h8E;
	localparam logic [7:0] A_P1 = 8'h90;
	localparam logic [7:0] A_P2 = 8'hA0;
	localparam logic [7:0] A_P3 = 8'hB0;
	localparam logic [7:0] A_TL2 = 8'hCC;
	localparam logic [7:0] A_TH2 = 8'hCD;
	localparam logic [7:0] A_STATUSW = 8'hD0;
	localparam logic [7:0] A_ARITH = 8'hE0;
	localparam logic [7:0] RST_PORT = 8'hFF;
	localparam logic [7:0] RST_SP = 8'h07;
	localparam logic [7:0] RST_PSEL = 8'h04;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam int PSEL_SEL_BIT = 0;
	localparam int PSEL_TOGGLE_BIT = 5;
	localparam int PSEL_AUTO_BIT = 4; // auto inc/dec enable
	localparam int PSEL_DEC_BIT = 6; // 1 = decrement
	localparam int TCTL_RUN0_BIT = 4;
	localparam int TCTL_RUN1_BIT = 6;
	localparam int TCTL_RUN2_BIT = 2;
	localparam int CLKC_FAST0_BIT = 3;
	localparam int NUM_TMR = 3;
	localparam logic [2:0] XMOVE_CYCLES = 3'h2;
	localparam logic [2:0] DMOVE_CYCLES = 3'h3;

	typedef enum logic [1:0] {
		SFRPC_OP_READ = 2'b00,
		SFRPC_OP_WRITE = 2'b01,
		SFRPC_OP_BITSET = 2'b10,
		SFRPC_OP_BITCLR = 2'b11
	} sfrpc_op_e;

	typedef struct packed {
		logic valid;
		logic direct; // 0 = indirect, must not reach the register space
		sfrpc_op_e op;
		logic [7:0] addr;
		logic [2:0] bit_idx;
		logic [7:0] wdata;
	} sfrpc_req_s;

	typedef struct packed {
		logic valid;
		logic hit;
		logic bit_val;
		logic [7:0] rdata;
	} sfrpc_rsp_s;
endpackage

// ==== sfrpc_seq_model.sv ====
/*
 * sfrpc_seq_model: behavioural instruction sequencer that issues register
 * requests, external data moves, flag updates and instruction boundaries.
 * Assumes the core samples all of these on the rising edge of sys_clk.
 */
`timescale 1ns/1ps
module sfrpc_seq_model
	import sfrpc_pkg::*;
(
	input wire logic sys_clk,
	output sfrpc_req_s req,
	output logic xmove,
	output logic [7:0] xmove_wdata,
	output logic xmove_wr,
	output logic instr_start,
	output logic instr_byte,
	output logic flags_wr,
	output logic [7:0] flags_val
);
	// quiet state at time zero
	initial begin
		req = '0;
		xmove = 1'b0;
		xmove_wdata = 8'h00;
		xmove_wr = 1'b0;
		instr_start = 1'b0;
		instr_byte = 1'b0;
		flags_wr = 1'b0;
		flags_val = 8'h00;
	end

	// one request, held for one edge; idle fields turn to inverted junk so stale values never pass
	task automatic acc(input sfrpc_op_e op, input logic dir, input logic [7:0] a, input logic [2:0] b,
		input logic [7:0] d, input logic fl, input logic [7:0] fv);
		sfrpc_req_s r;
		r = '{valid: 1'b1, direct: dir, op: op, addr: a, bit_idx: b, wdata: d};
		@(posedge sys_clk);
		req <= r;
		flags_wr <= fl;
		flags_val <= fv;
		@(posedge sys_clk);
		r = ~r;
		r.valid = 1'b0;
		req <= r;
		flags_wr <= 1'b0;
		flags_val <= ~fv;
	endtask

	// one external data move through the active pointer
	task automatic xmv(input logic wr, input logic [7:0] d);
		@(posedge sys_clk);
		xmove <= 1'b1;
		xmove_wr <= wr;
		xmove_wdata <= d;
		@(posedge sys_clk);
		xmove <= 1'b0;
		xmove_wr <= 1'b0;
		xmove_wdata <= ~d;
	endtask

	// instruction of len cycles, len of two at least
	task automatic instr(input int len);
		@(posedge sys_clk);
		instr_start <= 1'b1;
		instr_byte <= 1'b1;
		@(posedge sys_clk);
		instr_start <= 1'b0;
		instr_byte <= 1'b0;
		repeat (len - 2) @(posedge sys_clk);
	endtask
endmodule

// ==== sfrpc_timer.sv ====
/*
 * sfrpc_timer: one 16-bit timer/counter with a legacy twelve-clock prescaler
 * or per-clock rate. Assumes writes come from the register block, same clock.
 */
`timescale 1ns/1ps
module sfrpc_timer
	import sfrpc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic run,
	input wire logic fast,
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [7:0] wdata,
	output logic [15:0] count
);
	logic [3:0] pre_reg, pre_next;
	logic [15:0] cnt_reg, cnt_next;
	logic tick;

	// prescaler free-runs so the legacy rate stays phase-stable
	always_comb begin
		pre_next = (pre_reg == TMR_DIV_LAST) ? 4'h0 : pre_reg + 4'h1;
		tick = run && (fast || pre_reg == TMR_DIV_LAST);
		cnt_next = cnt_reg;
		if (tick) begin
			cnt_next = cnt_reg + 16'h0001;
		end
		// software write wins over a tick in the same cycle
		if (wr_lo) begin
			cnt_next[7:0] = wdata;
		end
		if (wr_hi) begin
			cnt_next[15:8] = wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pre_reg <= 4'h0;
			cnt_reg <= 16'h0000;
		end else begin
			pre_reg <= pre_next;
			cnt_reg <= cnt_next;
		end
	end

	assign count = cnt_reg;

	property p_legacy_rate;
		@(posedge sys_clk) disable iff (rst)
		(run && !fast && !wr_lo && !wr_hi && pre_reg == TMR_DIV_LAST) |=> (cnt_reg == $past(cnt_reg) + 16'h0001);
	endproperty
	a_legacy_rate: assert property (p_legacy_rate) else $error("legacy tick missed");

	property p_legacy_hold;
		@(posedge sys_clk) disable iff (rst)
		(!fast && !wr_lo && !wr_hi && pre_reg != TMR_DIV_LAST) |=> $stable(cnt_reg);
	endproperty
	a_legacy_hold: assert property (p_legacy_hold) else $error("timer moved off prescale tick");

	property p_fast_rate;
		@(posedge sys_clk) disable iff (rst)
		(run && fast && !wr_lo && !wr_hi) |=> (cnt_reg == $past(cnt_reg) + 16'h0001);
	endproperty
	a_fast_rate: assert property (p_fast_rate) else $error("fast timer did not count");
endmodule
